// [pkg/ms_ctrl_cfg.svh]
`ifndef MS_CTRL_CFG_SVH
`define MS_CTRL_CFG_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define ROW_COUNT      2
`define CHIPS_PER_ROW  4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SYS_STATUS_RST 1'b1
`define CE_CLOCK_RST   1'b0

`endif

// [pkg/ms_ctrl_pkg.sv]
package ms_ctrl_pkg;
    `include "ms_ctrl_cfg.svh"

    typedef enum logic [1:0] {
        ROW_PRESET = 2'b00,
        ROW_WAIT   = 2'b01,
        ROW_ACCESS = 2'b10,
        ROW_HOLD   = 2'b11
    } row_state_t;

    // per-row outputs carried together
    typedef struct packed {
        logic ce_clock;
        logic sys_status;
        logic ack;
    } row_out_t;
endpackage : ms_ctrl_pkg

// [src/ms_handshake_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ms_ctrl_cfg.svh"
// Contract
// - strobe follows the slowest chip
// - clock high until status has risen
// - clock rises only after last status fell
// - rising status ends write only if early
// - inverted status may self-clock the memory
// - hold request until acknowledge is low
module ms_handshake_ctrl
    import ms_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic                                    i_mclk,
    input  wire logic                                    i_rst,
    // using system
    input  wire logic                                    i_cycle_request,
    input  wire logic                                    i_row_select_bit,
    input  wire logic                                    i_interleave,
    input  wire logic                                    i_free_run,
    input  wire logic                                    i_step_gate,
    output logic                                         o_status_acknowledge,
    output logic                                         o_status_acknowledge_oe_n,
    output logic                                         o_sys_status,
    // memory rows
    input  wire logic [`ROW_COUNT*`CHIPS_PER_ROW-1:0]    i_mem_status_out,
    output logic      [`ROW_COUNT-1:0]                   o_ce_clock
);
    // ----------------------------------------------------------------
    // row steering
    // ----------------------------------------------------------------
    // without interleave both rows are driven by row 0's clock; status and acknowledge come from row 0 alone
    logic                  sel_row;
    row_out_t              row_out [`ROW_COUNT];
    logic [`ROW_COUNT-1:0] ce_next;

    assign sel_row = i_interleave & i_row_select_bit;

    for (genvar r = 0; r < `ROW_COUNT; r++) begin : g_row
        logic req;
        // with interleave, unselected rows see no request and stay preset; without it every row sees the request
        assign req = i_cycle_request & (!i_interleave || (sel_row == 1'(r)));
        row_clock_ctrl u_row (
            .i_mclk           (i_mclk),
            .i_rst            (i_rst),
            .i_mem_status_out (i_mem_status_out[r*`CHIPS_PER_ROW +: `CHIPS_PER_ROW]),
            .i_cycle_request  (req),
            .i_free_run       (i_free_run),
            .i_step_gate      (i_step_gate),
            .o_row            (row_out[r])
        );
        assign ce_next[r] = i_interleave ? row_out[r].ce_clock : row_out[0].ce_clock;
    end

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    // acknowledge lags the row latch by one cycle; cost of registered outputs
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_ce_clock                <= '0;
            o_status_acknowledge      <= 1'b1;
            o_status_acknowledge_oe_n <= 1'b0;
            o_sys_status              <= 1'b1;
        end else begin
            o_ce_clock                <= ce_next;
            o_status_acknowledge      <= row_out[sel_row].ack;
            o_status_acknowledge_oe_n <= 1'b0;
            o_sys_status              <= row_out[sel_row].sys_status;
        end
    end

    idle_row_a: assert property (@(posedge i_mclk) disable iff (i_rst || i_free_run)
        (i_interleave && !i_row_select_bit && !i_cycle_request && !o_ce_clock[1]) |=>
        !o_ce_clock[1]) else $error("unselected row clocked");
    ack_route_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        1'b1 |=> o_status_acknowledge ==
            $past((i_interleave && i_row_select_bit) ? row_out[1].ack : row_out[0].ack))
        else $error("acknowledge not from selected row");
    interleave_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        o_ce_clock[0] ##[1:30] o_ce_clock[1]);
endmodule : ms_handshake_ctrl
`default_nettype wire

// [src/row_clock_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ms_ctrl_cfg.svh"
module row_clock_ctrl
    import ms_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic                      i_mclk,
    input  wire logic                      i_rst,
    // chip side
    input  wire logic [`CHIPS_PER_ROW-1:0] i_mem_status_out,
    // control
    input  wire logic                      i_cycle_request,
    input  wire logic                      i_free_run,
    input  wire logic                      i_step_gate,
    // results
    output row_out_t                       o_row
);
    // ----------------------------------------------------------------
    // status coordination
    // ----------------------------------------------------------------
    logic       all_high;
    logic       all_low;
    logic       sys_status_reg;
    logic       ce_reg;
    logic       req_pend_reg;
    row_state_t state_reg;

    assign all_high = &i_mem_status_out;
    assign all_low  = ~|i_mem_status_out;

    // set/reset latch, holds while neither detection is true
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            sys_status_reg <= `SYS_STATUS_RST;
        end else if (all_high) begin
            sys_status_reg <= 1'b1;
        end else if (all_low) begin
            sys_status_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // clock latch, separate from status so status never depends on it
    // ----------------------------------------------------------------
    // a short request is remembered so it is not lost while preset runs;
    // requests during access or hold merge into that cycle, so a held
    // request never leaves a second cycle behind
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            req_pend_reg <= 1'b0;
        end else if (state_reg == ROW_ACCESS || state_reg == ROW_HOLD) begin
            req_pend_reg <= 1'b0;
        end else if (i_cycle_request) begin
            req_pend_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg <= ROW_PRESET;
            ce_reg    <= `CE_CLOCK_RST;
        end else if (i_free_run) begin
            // feedback path, gated for single stepping
            ce_reg    <= ~sys_status_reg & i_step_gate;
            state_reg <= ROW_PRESET;
        end else begin
            unique case (state_reg)
                ROW_PRESET: begin
                    ce_reg <= 1'b0;
                    if (req_pend_reg | i_cycle_request) begin
                        state_reg <= ROW_WAIT;
                    end
                end
                ROW_WAIT: begin
                    // preset incomplete: wait before raising the clock
                    if (!sys_status_reg) begin
                        ce_reg    <= 1'b1;
                        state_reg <= ROW_ACCESS;
                    end
                end
                ROW_ACCESS: begin
                    // clock stays high until every chip reports data valid
                    if (sys_status_reg && all_high) begin
                        state_reg <= ROW_HOLD;
                    end
                end
                ROW_HOLD: begin
                    // read-modify-write: hold clock while request stays high
                    if (!i_cycle_request) begin
                        ce_reg    <= 1'b0;
                        state_reg <= ROW_PRESET;
                    end
                end
            endcase
        end
    end

    assign o_row.ce_clock   = ce_reg;
    assign o_row.sys_status = sys_status_reg;
    assign o_row.ack        = sys_status_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sys_status_set_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        all_high |=> sys_status_reg) else $error("status not set on all high");
    sys_status_clr_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        all_low |=> !sys_status_reg) else $error("status not cleared on all low");
    status_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!all_high && !all_low) |=> $stable(sys_status_reg))
        else $error("status changed without detection");
    ce_wait_a: assert property (@(posedge i_mclk) disable iff (i_rst || i_free_run)
        $rose(ce_reg) |-> !$past(sys_status_reg)) else $error("clock rose before preset");
    ce_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst || i_free_run)
        (ce_reg && !sys_status_reg) |=> ce_reg) else $error("clock dropped before access");
    rmw_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst || i_free_run)
        (state_reg == ROW_HOLD && i_cycle_request) |=> ce_reg)
        else $error("clock dropped during held request");
    hold_exit_a: assert property (@(posedge i_mclk) disable iff (i_rst || i_free_run)
        (state_reg == ROW_HOLD && !i_cycle_request) |=> !req_pend_reg)
        else $error("second cycle left pending after hold");
    free_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_free_run && !i_step_gate) |=> !ce_reg) else $error("gate did not block clock");
    free_run_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (i_free_run && i_step_gate) |=> ce_reg == !$past(sys_status_reg))
        else $error("free-run clock wrong");
    one_cycle_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        state_reg == ROW_ACCESS ##[1:20] state_reg == ROW_PRESET);
    rmw_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        state_reg == ROW_HOLD && i_cycle_request ##1 state_reg == ROW_HOLD);
    free_c: cover property (@(posedge i_mclk) disable iff (i_rst)
        i_free_run && $rose(ce_reg));
endmodule : row_clock_ctrl
`default_nettype wire

// [verif/mem_chip_model.sv]
`timescale 1ns/100ps
`default_nettype none
module mem_chip_model #(
    parameter int ACC = 3,
    parameter int PRE = 2
) (
    // clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst,
    // chip enable in, status out
    input  wire logic i_ce,
    output logic      o_mem_status_out
);
    // ----------------------------------------------------------------
    // status timing
    // ----------------------------------------------------------------
    // status is always driven, never three-state, so no idle pattern
    int cnt;
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_mem_status_out <= 1'b0;
            cnt              <= 0;
        end else if (o_mem_status_out != i_ce) begin
            cnt <= cnt + 1;
            if (cnt + 1 >= (i_ce ? ACC : PRE)) begin
                o_mem_status_out <= ~o_mem_status_out;
                cnt              <= 0;
            end
        end else begin
            cnt <= 0;
        end
    end
endmodule : mem_chip_model
`default_nettype wire

// [verif/memory_status_handshake_clock_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ms_ctrl_cfg.svh"
module memory_status_handshake_clock_tb;
    import ms_ctrl_pkg::*;
    localparam int NC = `CHIPS_PER_ROW;
    logic                        i_mclk, i_rst, req, sel, ilv, fr, gate;
    logic                        ack, oe_n, sst;
    logic [`ROW_COUNT-1:0]       ce, ce_q;
    logic [`ROW_COUNT*NC-1:0]    st;
    int                          err_count, n_compared, rises;

    ms_handshake_ctrl ms_handshake_ctrl_inst (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_cycle_request(req), .i_row_select_bit(sel), .i_interleave(ilv),
        .i_free_run(fr), .i_step_gate(gate), .o_status_acknowledge(ack),
        .o_status_acknowledge_oe_n(oe_n), .o_sys_status(sst),
        .i_mem_status_out(st), .o_ce_clock(ce));
    // each chip of a row is slower than the one before it
    for (genvar g = 0; g < `ROW_COUNT * NC; g++) begin : g_chip
        mem_chip_model #(.ACC(2 + g % NC), .PRE(1 + g % NC)) mem_chip_model_inst (
            .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce[g / NC]), .o_mem_status_out(st[g]));
    end

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    initial begin
        #50us;
        err_count++;
        stop_test();
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : cyc
    task automatic wait_st(input logic [NC-1:0] v, input int r);
        int k;
        k = 0;
        while (st[r*NC +: NC] !== v && k < 100) begin
            cyc(1);
            k++;
        end
        chk(8'(k < 100), 8'h01);
    endtask : wait_st
    // ack follows the slowest chip by two edges, both ways
    task automatic ack_edge(input int r, input logic v);
        wait_st({NC{v}}, r);
        cyc(1);
        chk(8'(ack), 8'(!v));
        cyc(1);
        chk(8'(ack), 8'(v));
    endtask : ack_edge
    task automatic pulse;
        req = 1'b1;
        cyc(1);
        req = 1'b0;
    endtask : pulse
    // ce may only rise on a fully preset row, and outside free run only fall once it is all high
    always @(negedge i_mclk) begin
        for (int r = 0; r < `ROW_COUNT; r++) begin
            if (!i_rst && ce[r] && !ce_q[r]) begin
                rises += (r == 0);
                chk(8'(st[r*NC +: NC]), 8'h00);
            end
            if (!i_rst && !fr && !ce[r] && ce_q[r]) chk(8'(st[r*NC +: NC]), 8'h0f);
        end
        ce_q = ce;
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_single;
        pulse();
        ack_edge(0, 1'b1);
        ack_edge(0, 1'b0);
        cyc(20);
        chk(8'({ce, ack}), 8'h00);
        $display("single cycle test done");
    endtask : t_single
    task automatic t_held_and_deferred;
        req = 1'b1;
        ack_edge(0, 1'b1);
        cyc(10);
        chk(8'({ce[0], st[NC-1:0]}), 8'h1f);
        req = 1'b0;
        cyc(1);
        // asked while still presetting, so the request stands until ack falls
        req = 1'b1;
        ack_edge(0, 1'b0);
        req = 1'b0;
        ack_edge(0, 1'b1);
        ack_edge(0, 1'b0);
        $display("held and deferred test done");
    endtask : t_held_and_deferred
    task automatic t_interleave;
        ilv = 1'b1;
        for (int r = 1; r >= 0; r--) begin
            sel = r[0];
            pulse();
            ack_edge(r, 1'b1);
            chk(8'({ce[1 - r], oe_n, sst}), 8'h01);
            ack_edge(r, 1'b0);
        end
        $display("interleave test done");
    endtask : t_interleave
    task automatic t_free_run;
        fr = 1'b1;
        rises = 0;
        cyc(80);
        chk(8'(rises >= 3), 8'h01);
        gate = 1'b0;
        cyc(30);
        rises = 0;
        cyc(40);
        chk(8'({rises[3:0], ce}), 8'h00);
        $display("free run test done");
    endtask : t_free_run

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    initial begin
        i_rst = 1'b1;
        {req, sel, ilv, fr} = 4'h0;
        gate = 1'b1;
        ce_q = '0;
        err_count = 0;
        n_compared = 0;
        rises = 0;
        cyc(8);
        chk(8'({ce, ack, oe_n, sst}), 8'h05);
        i_rst = 1'b0;
        cyc(5);
        chk(8'(ack), 8'h00);
        $display("reset test done");
        t_single();
        t_held_and_deferred();
        t_interleave();
        t_free_run();
        stop_test();
    end
endmodule : memory_status_handshake_clock_tb
`default_nettype wire
